/* rtl/uotg_defs.svh */
`ifndef UOTG_DEFS_SVH
`define UOTG_DEFS_SVH
// Register byte addresses.
`define UOTG_ADDR_FUNC     12'h000
`define UOTG_ADDR_TOKEN    12'h004
`define UOTG_ADDR_FLAGS    12'h008
`define UOTG_ADDR_ERR_EN   12'h00c
`define UOTG_ADDR_IRQ_MASK 12'h010
`define UOTG_ADDR_STATUS   12'h014
`define UOTG_ADDR_CTRL     12'h018
// Field positions.
`define UOTG_LOW_SPEED_BIT 7
`define UOTG_FLAG_STALL    7
`define UOTG_FLAG_RESUME   5
`define UOTG_FLAG_IDLE     4
`define UOTG_FLAG_TOKDONE  3
`define UOTG_FLAG_SOF      2
`define UOTG_FLAG_ERR      1
`define UOTG_FLAG_RESET    0
// Implemented-bit masks and reset values.
`define UOTG_FLAG_MASK     8'hbf
`define UOTG_ERR_EN_MASK   8'hbf
`define UOTG_RESET_VAL     8'h00
// Token type encodings.
`define UOTG_PID_SETUP     4'hd
`define UOTG_PID_IN        4'h9
`define UOTG_PID_OUT       4'h1
// Resume K-state time: 2.5 us, counted at 50 MHz.
`define UOTG_RESUME_NS     2500
`define UOTG_CLK_MHZ       50
`define UOTG_RESUME_CYC    ((`UOTG_RESUME_NS * `UOTG_CLK_MHZ + 999) / 1000)
`endif

/* rtl/uotg_pkg.sv */
`default_nettype none
package uotg_pkg;
  typedef enum logic [1:0] {UOTG_TOK_SETUP, UOTG_TOK_IN, UOTG_TOK_OUT, UOTG_TOK_NONE} uotg_tok_t;
  typedef enum {UOTG_IDLE, UOTG_BUSY} uotg_state_t;
endpackage
`default_nettype wire

/* rtl/uotg_kstate_det.sv */
`include "uotg_defs.svh"
`default_nettype none
// Detects a K-state held on the lines for the resume time.
module uotg_kstate_det (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic dp_pin,
  input  wire logic dm_pin,
  input  wire logic low_speed,
  output logic      resume_pulse
);
  logic [2:0] dp_sync;
  logic [2:0] dm_sync;
  logic       dp_q;
  logic       dm_q;
  logic       k_state;
  logic [7:0] k_count;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_sync <= 3'h0;
      dm_sync <= 3'h0;
    end else begin
      dp_sync <= {dp_sync[1:0], dp_pin};
      dm_sync <= {dm_sync[1:0], dm_pin};
    end
  end

  // A change counts once the second and third stages agree.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_q <= 1'b0;
      dm_q <= 1'b0;
    end else begin
      if (dp_sync[1] == dp_sync[2]) dp_q <= dp_sync[2];
      if (dm_sync[1] == dm_sync[2]) dm_q <= dm_sync[2];
    end
  end

  assign k_state = low_speed ? (dp_q && !dm_q) : (!dp_q && dm_q);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      k_count      <= 8'h00;
      resume_pulse <= 1'b0;
    end else begin
      resume_pulse <= 1'b0;
      if (!k_state) begin
        k_count <= 8'h00;
      end else if (k_count < 8'(`UOTG_RESUME_CYC)) begin
        k_count <= k_count + 8'h01;
        if (k_count == 8'(`UOTG_RESUME_CYC - 1)) resume_pulse <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/uotg_regs.sv */
`include "uotg_defs.svh"
`default_nettype none
module uotg_regs (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        host_mode,
  input  wire logic        stall_sent,
  input  wire logic        idle_seen,
  input  wire logic        token_done,
  input  wire logic        frame_start,
  input  wire logic        bus_reset_seen,
  input  wire logic [7:0]  err_events,
  input  wire logic        token_complete,
  input  wire logic        dp_pin,
  input  wire logic        dm_pin,
  output logic             irq,
  output logic             low_speed,
  output logic [6:0]       func_addr,
  output logic             token_start,
  output uotg_pkg::uotg_tok_t token_kind,
  output logic [3:0]       token_ep,
  output logic             token_busy
);
  import uotg_pkg::*;

  logic [7:0]  usb_function_address;
  logic [7:0]  usb_host_token_launch;
  logic [7:0]  usb_device_interrupt_flags;
  logic [7:0]  usb_error_interrupt_enables;
  logic [7:0]  irq_mask;
  logic        resume_pulse;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  next_flags;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;
  logic        err_summary;
  logic [31:0] next_rdata;
  logic        addr_ok;
  uotg_state_t tok_state;

  function automatic uotg_tok_t decode_pid(input logic [3:0] pid);
    uotg_tok_t kind;
    kind = UOTG_TOK_NONE;
    if (pid == `UOTG_PID_SETUP) kind = UOTG_TOK_SETUP;
    else if (pid == `UOTG_PID_IN) kind = UOTG_TOK_IN;
    else if (pid == `UOTG_PID_OUT) kind = UOTG_TOK_OUT;
    return kind;
  endfunction

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  // Access phase completes in one cycle; pready is registered from the setup cycle and is high only in the first access cycle.
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  uotg_kstate_det u_kdet (
    .clk          (clk),
    .rst_b        (rst_b),
    .dp_pin       (dp_pin),
    .dm_pin       (dm_pin),
    .low_speed    (1'b0),
    .resume_pulse (resume_pulse)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      usb_function_address <= `UOTG_RESET_VAL;
    end else if (wr_en && is_addr(paddr, `UOTG_ADDR_FUNC)) begin
      usb_function_address <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_speed <= 1'b0;
      func_addr <= 7'h00;
    end else begin
      low_speed <= host_mode && usb_function_address[`UOTG_LOW_SPEED_BIT];
      func_addr <= usb_function_address[6:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      usb_host_token_launch <= `UOTG_RESET_VAL;
      token_start           <= 1'b0;
      token_kind            <= UOTG_TOK_NONE;
      token_ep              <= 4'h0;
      tok_state             <= UOTG_IDLE;
      token_busy            <= 1'b0;
    end else begin
      token_start <= 1'b0;
      if (wr_en && is_addr(paddr, `UOTG_ADDR_TOKEN)) begin
        usb_host_token_launch <= pwdata[7:0];
      end
      case (tok_state)
        UOTG_IDLE: begin
          if (wr_en && is_addr(paddr, `UOTG_ADDR_TOKEN) && host_mode &&
              decode_pid(pwdata[7:4]) != UOTG_TOK_NONE) begin
            token_kind  <= decode_pid(pwdata[7:4]);
            token_ep    <= pwdata[3:0];
            token_start <= 1'b1;
            token_busy  <= 1'b1;
            tok_state   <= UOTG_BUSY;
          end
        end
        UOTG_BUSY: begin
          if (token_complete || !host_mode) begin
            token_busy <= 1'b0;
            tok_state  <= UOTG_IDLE;
          end
        end
        default: tok_state <= UOTG_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      usb_error_interrupt_enables <= `UOTG_RESET_VAL;
      irq_mask                    <= `UOTG_RESET_VAL;
    end else if (wr_en) begin
      if (is_addr(paddr, `UOTG_ADDR_ERR_EN)) begin
        usb_error_interrupt_enables <= pwdata[7:0] & `UOTG_ERR_EN_MASK;
      end else if (is_addr(paddr, `UOTG_ADDR_IRQ_MASK)) begin
        irq_mask <= pwdata[7:0] & `UOTG_FLAG_MASK;
      end
    end
  end

  // bit 1 covers CRC5 or end-of-frame by mode
  assign err_summary = |(err_events & usb_error_interrupt_enables);

  always_comb begin
    flag_set = 8'h00;
    if (!host_mode) begin
      flag_set[`UOTG_FLAG_STALL]   = stall_sent;
      flag_set[`UOTG_FLAG_RESUME]  = resume_pulse;
      flag_set[`UOTG_FLAG_IDLE]    = idle_seen;
      flag_set[`UOTG_FLAG_TOKDONE] = token_done;
      flag_set[`UOTG_FLAG_SOF]     = frame_start;
      flag_set[`UOTG_FLAG_RESET]   = bus_reset_seen;
    end
    flag_clr = 8'h00;
    if (wr_en && is_addr(paddr, `UOTG_ADDR_FLAGS)) flag_clr = pwdata[7:0];
    next_flags = ((usb_device_interrupt_flags & ~flag_clr) | flag_set) & `UOTG_FLAG_MASK;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      usb_device_interrupt_flags <= `UOTG_RESET_VAL;
    end else begin
      usb_device_interrupt_flags <= next_flags;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_flags & irq_mask) || (err_summary && !host_mode && irq_mask[`UOTG_FLAG_ERR]);
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    addr_ok    = 1'b1;
    if (is_addr(paddr, `UOTG_ADDR_FUNC)) begin
      // low-speed bit hidden in device mode
      next_rdata[7:0] = {usb_function_address[7] & host_mode, usb_function_address[6:0]};
    end else if (is_addr(paddr, `UOTG_ADDR_TOKEN)) begin
      next_rdata[7:0] = usb_host_token_launch;
    end else if (is_addr(paddr, `UOTG_ADDR_FLAGS)) begin
      next_rdata[7:0] = usb_device_interrupt_flags;
      // error summary shown in device mode
      next_rdata[`UOTG_FLAG_ERR] = err_summary && !host_mode;
    end else if (is_addr(paddr, `UOTG_ADDR_ERR_EN)) begin
      next_rdata[7:0] = usb_error_interrupt_enables;
    end else if (is_addr(paddr, `UOTG_ADDR_IRQ_MASK)) begin
      next_rdata[7:0] = irq_mask;
    end else if (is_addr(paddr, `UOTG_ADDR_STATUS)) begin
      next_rdata[1:0] = {host_mode, token_busy};
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= (psel && !penable && !pwrite) ? next_rdata : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

/* tb/uotg_regs_props.sv */
`include "uotg_defs.svh"
`default_nettype none
module uotg_regs_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        host_mode,
  input wire logic        low_speed,
  input wire logic [6:0]  func_addr,
  input wire logic        token_start,
  input wire logic        token_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence acc_s;
    psel && penable && pready;
  endsequence
  sequence tok_wr_s;
    acc_s ##0 (pwrite && paddr == `UOTG_ADDR_TOKEN);
  endsequence
  unmapped_err_a: assert property (acc_s ##0 paddr > `UOTG_ADDR_CTRL |-> pslverr)
    else $error("no slave error");
  addr_store_a: assert property (acc_s ##0 (pwrite && paddr == `UOTG_ADDR_FUNC)
    |=> ##1 func_addr == $past(pwdata[6:0], 2)) else $error("address not stored");
  speed_dev_a: assert property ($past(host_mode) == 1'b0 |-> !low_speed)
    else $error("low speed in device mode");
  ls_read_a: assert property (
    acc_s ##0 (!pwrite && !host_mode && paddr == `UOTG_ADDR_FUNC) |-> !prdata[7])
    else $error("speed bit read as one");
  tok_launch_a: assert property (
    tok_wr_s ##0 (host_mode && !token_busy && pwdata[7:4] inside
    {`UOTG_PID_SETUP, `UOTG_PID_IN, `UOTG_PID_OUT}) |=> token_start)
    else $error("token not launched");
  tok_refuse_a: assert property (tok_wr_s ##0 !host_mode |=> !token_start)
    else $error("token launched in device mode");
  start_cause_a: assert property (token_start |-> $past(penable) && $past(pwrite) &&
    $past(paddr) == `UOTG_ADDR_TOKEN) else $error("token start without write");
  read_upper_a: assert property (acc_s ##0 !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule
bind uotg_regs uotg_regs_chk uotg_regs_chk_i (.*);
`default_nettype wire

/* tb/uotg_cable_model.sv */
`default_nettype none
module uotg_cable_model (
  input  wire logic clk,
  input  wire logic token_start,
  output logic      dp_pin,
  output logic      dm_pin,
  output logic      token_complete
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {dp_pin, dm_pin, token_complete} = 3'b100;
  end
  always @(posedge clk) begin
    if (token_start === 1'b1) begin
      repeat ($urandom_range(20, 1)) @(posedge clk);
      token_complete <= 1'b1;
      @(posedge clk);
      token_complete <= 1'b0;
    end
  end
  task automatic send_k(input int n);
    {dp_pin, dm_pin} <= 2'b01;
    repeat (n) @(posedge clk);
    {dp_pin, dm_pin} <= 2'b10;
  endtask
endmodule
`default_nettype wire

/* tb/test_usb_otg_addr_token_irq_regs.sv */
`include "uotg_defs.svh"
`default_nettype none
module test_usb_otg_addr_token_irq_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import uotg_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, host_mode, pready, pslverr, er, go;
  logic        irq, low_speed, token_start, token_busy, token_complete, dp_pin, dm_pin;
  logic [4:0]  ev, e;
  logic [7:0]  m;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, wd;
  logic [6:0]  func_addr;
  logic [3:0]  token_ep, ep_seen;
  logic [3:0]  pids [4] = '{4'hd, 4'h9, 4'h1, 4'h6};
  uotg_tok_t   token_kind, kind_seen;
  int          err_total = 0, checks_done = 0, starts = 0, n0;
  uotg_regs uotg_regs_i (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .host_mode, .stall_sent(ev[4]), .idle_seen(ev[3]),
    .token_done(ev[2]), .frame_start(ev[1]), .bus_reset_seen(ev[0]), .err_events(8'h00),
    .token_complete, .dp_pin, .dm_pin, .irq, .low_speed, .func_addr, .token_start,
    .token_kind, .token_ep, .token_busy);
  uotg_cable_model uotg_cable_model_i (.clk, .token_start, .dp_pin, .dm_pin, .token_complete);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (token_start === 1'b1) begin
      starts++;
      kind_seen = token_kind;
      ep_seen = token_ep;
    end
  end
  function automatic logic [31:0] flag_of(input logic [4:0] f);
    return {24'h0, f[4], 2'b00, f[3:1], 1'b0, f[0]};
  endfunction
  function automatic uotg_tok_t kind_of(input logic [3:0] t);
    case (t)
      4'hd: return UOTG_TOK_SETUP;
      4'h9: return UOTG_TOK_IN;
      4'h1: return UOTG_TOK_OUT;
      default: return UOTG_TOK_NONE;
    endcase
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, we, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    // A slave that never answers ends the run as a mismatch.
    if (pready !== 1'b1) begin
      err_total++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 0);
    chk(rd, exp);
  endtask
  initial begin
    {rst_b, psel, penable, pwrite, host_mode, ev, paddr, pwdata} = '0;
    void'($urandom(76083));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rdc(12'(i * 4), 0);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      host_mode <= i[0];
      wd = $urandom;
      apb(1'b1, `UOTG_ADDR_FUNC, wd);
      @(posedge clk);
      chk(32'(func_addr), 32'(wd[6:0]));
      chk(32'(low_speed), 32'(i[0] & wd[7]));
      rdc(`UOTG_ADDR_FUNC, {24'h0, i[0] & wd[7], wd[6:0]});
    end
    repeat (8) begin
      wd = $urandom;
      apb(1'b1, `UOTG_ADDR_ERR_EN, wd);
      rdc(`UOTG_ADDR_ERR_EN, 32'(wd[7:0] & 8'hbf));
    end
    apb(1'b0, 12'h0f0, 0);
    chk(32'(er), 1);
    $display("register test done");
    host_mode <= 1'b0;
    repeat (8) begin
      e = 5'($urandom);
      m = 8'($urandom);
      ev <= e;
      @(posedge clk);
      ev <= 5'h0;
      apb(1'b1, `UOTG_ADDR_IRQ_MASK, 32'(m));
      apb(1'b1, `UOTG_ADDR_FLAGS, 0);
      rdc(`UOTG_ADDR_FLAGS, flag_of(e));
      @(posedge clk);
      chk(32'(irq), 32'(|(flag_of(e) & 32'(m))));
      apb(1'b1, `UOTG_ADDR_FLAGS, 32'hff);
    end
    for (int k = 0; k < 2; k++) begin
      uotg_cable_model_i.send_k(k ? 140 : 100);
      repeat (8) @(posedge clk);
      rdc(`UOTG_ADDR_FLAGS, k ? 32'h20 : 32'h0);
      apb(1'b1, `UOTG_ADDR_FLAGS, 32'hff);
    end
    $display("flag test done");
    for (int i = 0; i < 12; i++) begin
      host_mode <= (i < 8);
      wd = {24'h0, pids[i % 4], 4'($urandom)};
      n0 = starts;
      apb(1'b1, `UOTG_ADDR_TOKEN, wd);
      @(posedge clk);
      for (int w = 0; w < 40 && token_busy !== 1'b0; w++) @(posedge clk);
      if (token_busy !== 1'b0) begin
        err_total++;
        print_verdict();
      end
      go = (i < 8) && (i % 4 != 3);
      chk(32'(starts - n0), 32'(go));
      if (go) chk(32'(kind_seen), 32'(kind_of(wd[7:4])));
      if (go) chk(32'(ep_seen), 32'(wd[3:0]));
      rdc(`UOTG_ADDR_TOKEN, wd);
    end
    $display("token test done");
    print_verdict();
  end
endmodule
`default_nettype wire
